// File: rtl/adc_sequencer.sv
// Sequencer, trigger, averaging and result formatting around a 10-bit
// converter core. Assumes an APB master on CLOCK and a converter core
// that answers each start with one CONV_DONE pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none

module adc_sequencer (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [3:0]  TRIG_IN,
  output logic             CONV_START,
  output logic      [3:0]  CONV_CHAN,
  output logic      [3:0]  CONV_CHAN_NEG,
  output logic             CONV_DIFF,
  output logic             CONV_TEMP,
  input  wire logic        CONV_DONE,
  input  wire logic [9:0]  CONV_CODE
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]        enable;
    logic [15:0]       emux;
    logic [15:0]       pri;
    logic [2:0]        sac;
    logic              loopback;
    logic [3:0][31:0]  mux;
    logic [3:0][31:0]  ctl;
    logic [3:0]        pending;
    logic [3:0]        ovf;
    adc_seq_pkg::seq_state_e state;
    logic [1:0]        cur;
    logic [2:0]        step;
    logic [6:0]        avg_cnt;
    logic [15:0]       acc;
    logic              apb_wait;
    logic [31:0]       prdata;
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic [3:0]        sync3;
    logic [3:0]        trig_lvl;
    logic [9:0]        lb_code;
    logic              lb_done;
    logic              conv_start;
    logic [3:0]        conv_chan;
    logic [3:0]        conv_neg;
    logic              conv_diff;
    logic              conv_temp;
  } core_s;

  core_s r;
  core_s n;

  logic [3:0]  hit;
  logic [3:0]  pend_clr;
  logic [3:0]  ovf_clr;
  logic [3:0]  ovf_set;
  logic [3:0]  trig_rise;
  logic [3:0]  code;
  logic [1:0]  best;
  logic [1:0]  best_pri;
  logic        best_ok;
  logic [3:0]  nib_in;
  logic [3:0]  nib_ctl;
  logic        conv_done;
  logic [10:0] dsum;
  logic [9:0]  sample;
  logic [15:0] acc_sum;
  logic [15:0] mean;
  logic [2:0]  sac_eff;
  logic [6:0]  avg_goal;
  logic        last_step;
  logic        done_ph;
  logic        in_seq;
  logic [1:0]  sidx;
  logic [4:0]  sub;
  logic        mapped;
  logic [31:0] rd_value;
  logic [3:0]  fifo_wr;
  logic [3:0]  fifo_pop;
  logic [9:0]  fifo_wdata;
  logic [9:0]  fifo_rdata [adc_seq_pkg::NSEQ];
  logic [3:0]  fifo_full;
  logic [3:0]  fifo_empty;

  // ---------------------------------------------------------------
  // Result buffers, one per sequencer
  // ---------------------------------------------------------------
  for (genvar g = 0; g < adc_seq_pkg::NSEQ; g++) begin : g_fifo
    result_fifo #(
      .DEPTH (adc_seq_pkg::SEQ_DEPTH[g]),
      .WIDTH (adc_seq_pkg::CODE_W)
    ) u_fifo (
      .clk     (CLOCK),
      .srst    (SRST),
      .wr_en   (fifo_wr[g]),
      .wr_data (fifo_wdata),
      .rd_en   (fifo_pop[g]),
      .rd_data (fifo_rdata[g]),
      .full    (fifo_full[g]),
      .empty   (fifo_empty[g])
    );
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Every APB access takes one wait state so that read data, and the
  // buffer head in particular, can come from a register.
  always_comb begin
    n          = r;
    hit        = '0;
    pend_clr   = '0;
    ovf_clr    = '0;
    ovf_set    = '0;
    fifo_wr    = '0;
    fifo_pop   = '0;
    code       = '0;
    best       = '0;
    best_pri   = 2'h3;
    best_ok    = 1'b0;
    rd_value   = '0;
    mapped     = 1'b0;
    n.conv_start = 1'b0;
    n.lb_done    = 1'b0;

    // Trigger pins: the level moves only once stages two and three agree.
    n.sync1 = TRIG_IN;
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;
    if (r.sync2 == r.sync3) begin
      n.trig_lvl = r.sync3;
    end
    trig_rise = n.trig_lvl & ~r.trig_lvl;

    // Address decode.
    done_ph = PSEL && PENABLE && r.apb_wait;
    n.apb_wait = PSEL && PENABLE && !r.apb_wait;
    in_seq = (PADDR[11:8] == 4'h0) && (PADDR[1:0] == 2'b00)
          && (PADDR[7:5] >= adc_seq_pkg::SEQ_BLK_FIRST)
          && (PADDR[7:5] <= adc_seq_pkg::SEQ_BLK_LAST);
    sidx = 2'(PADDR[7:5] - adc_seq_pkg::SEQ_BLK_FIRST);
    sub  = PADDR[4:0];
    if (in_seq) begin
      mapped = (sub == adc_seq_pkg::SUB_MUX) || (sub == adc_seq_pkg::SUB_CTL)
            || (sub == adc_seq_pkg::SUB_FIFO)
            || (sub == adc_seq_pkg::SUB_STAT);
      if (sub == adc_seq_pkg::SUB_MUX) rd_value = r.mux[sidx];
      if (sub == adc_seq_pkg::SUB_CTL) rd_value = r.ctl[sidx];
      if (sub == adc_seq_pkg::SUB_FIFO) begin
        rd_value = {22'h000000, fifo_rdata[sidx]};
      end
      if (sub == adc_seq_pkg::SUB_STAT) begin
        rd_value[adc_seq_pkg::STAT_EMPTY] = fifo_empty[sidx];
        rd_value[adc_seq_pkg::STAT_FULL]  = fifo_full[sidx];
      end
    end else begin
      unique case (PADDR)
        adc_seq_pkg::OFF_ACTIVE: begin
          mapped = 1'b1;
          rd_value = {28'h0000000, r.enable};
        end
        adc_seq_pkg::OFF_OVERFLOW: begin
          mapped = 1'b1;
          rd_value = {28'h0000000, r.ovf};
        end
        adc_seq_pkg::OFF_EVENT: begin
          mapped = 1'b1;
          rd_value = {16'h0000, r.emux};
        end
        adc_seq_pkg::OFF_PRIORITY: begin
          mapped = 1'b1;
          rd_value = {16'h0000, r.pri};
        end
        adc_seq_pkg::OFF_INITIATE: begin
          mapped = 1'b1;
        end
        adc_seq_pkg::OFF_AVERAGE: begin
          mapped = 1'b1;
          rd_value = {29'h00000000, r.sac};
        end
        adc_seq_pkg::OFF_LOOPBACK: begin
          mapped = 1'b1;
          rd_value = {31'h00000000, r.loopback};
        end
        default: mapped = 1'b0;
      endcase
    end
    if (PSEL && PENABLE && !r.apb_wait) begin
      n.prdata = rd_value;
    end

    // Writes act at the completing edge; settings are open at all times.
    if (done_ph && PWRITE && mapped) begin
      if (in_seq && sub == adc_seq_pkg::SUB_MUX) begin
        n.mux[sidx] = PWDATA & adc_seq_pkg::SEQ_MASK[sidx];
      end
      if (in_seq && sub == adc_seq_pkg::SUB_CTL) begin
        n.ctl[sidx] = PWDATA & adc_seq_pkg::SEQ_MASK[sidx];
      end
      if (!in_seq) begin
        unique case (PADDR)
          adc_seq_pkg::OFF_ACTIVE:   n.enable = PWDATA[3:0];
          adc_seq_pkg::OFF_OVERFLOW: ovf_clr = PWDATA[3:0];
          adc_seq_pkg::OFF_EVENT:    n.emux = PWDATA[15:0];
          adc_seq_pkg::OFF_PRIORITY: begin
            n.pri = PWDATA[15:0] & adc_seq_pkg::PRI_MASK;
          end
          adc_seq_pkg::OFF_INITIATE: hit = PWDATA[3:0];
          adc_seq_pkg::OFF_AVERAGE:  n.sac = PWDATA[2:0];
          adc_seq_pkg::OFF_LOOPBACK: n.loopback = PWDATA[0];
          default: n.loopback = r.loopback;
        endcase
      end
    end
    // Reading a result word pops it; an empty buffer is left alone.
    if (done_ph && !PWRITE && in_seq && sub == adc_seq_pkg::SUB_FIFO) begin
      fifo_pop[sidx] = 1'b1;
    end

    // Trigger selection per sequencer.
    for (int g = 0; g < adc_seq_pkg::NSEQ; g++) begin
      code = r.emux[4*g +: 4];
      if (code == adc_seq_pkg::TRIG_PROC) begin
        hit[g] = hit[g];
      end else if (code == adc_seq_pkg::TRIG_ALWAYS) begin
        hit[g] = 1'b1;
      end else if (code >= adc_seq_pkg::TRIG_EXT_FIRST
                && code <= adc_seq_pkg::TRIG_EXT_LAST) begin
        hit[g] = trig_rise[2'(code - adc_seq_pkg::TRIG_EXT_FIRST)];
      end else begin
        hit[g] = 1'b0;
      end
    end

    // Lowest priority value wins; ties go to the lower sequencer.
    for (int g = 0; g < adc_seq_pkg::NSEQ; g++) begin
      if (r.pending[g] && (!best_ok || r.pri[4*g +: 2] < best_pri)) begin
        best_ok  = 1'b1;
        best_pri = r.pri[4*g +: 2];
        best     = 2'(g);
      end
    end

    // Step fields and result formatting.
    nib_in  = r.mux[r.cur][{r.step, 2'b00} +: 4];
    nib_ctl = r.ctl[r.cur][{r.step, 2'b00} +: 4];
    conv_done = r.loopback ? r.lb_done : CONV_DONE;
    dsum = {CONV_CODE[9], CONV_CODE} + adc_seq_pkg::DIFF_ZERO;
    if (r.loopback) begin
      sample = r.lb_code;
    end else if (r.conv_diff) begin
      sample = dsum[10] ? 10'h000 : dsum[9:0];
    end else begin
      sample = CONV_CODE;
    end
    sac_eff  = (r.sac > adc_seq_pkg::SAC_MAX) ? adc_seq_pkg::SAC_MAX
                                              : r.sac;
    avg_goal = 7'h01 << sac_eff;
    acc_sum  = r.acc + {6'h00, sample};
    mean     = acc_sum >> sac_eff;
    fifo_wdata = mean[9:0];
    last_step = nib_ctl[adc_seq_pkg::CTL_END]
             || (r.step == 3'(adc_seq_pkg::SEQ_DEPTH[r.cur] - 1));

    // Sequence engine.
    unique case (r.state)
      adc_seq_pkg::ST_IDLE: begin
        if (best_ok) begin
          n.cur     = best;
          n.step    = '0;
          n.avg_cnt = '0;
          n.acc     = '0;
          n.state   = adc_seq_pkg::ST_ISSUE;
        end
      end
      adc_seq_pkg::ST_ISSUE: begin
        if (!r.enable[r.cur]) begin
          n.state = adc_seq_pkg::ST_IDLE;
        end else begin
          n.conv_start = !r.loopback;
          n.lb_done    = r.loopback;
          n.conv_diff  = nib_ctl[adc_seq_pkg::CTL_DIFF];
          n.conv_temp  = nib_ctl[adc_seq_pkg::CTL_TEMP];
          if (nib_ctl[adc_seq_pkg::CTL_DIFF]) begin
            n.conv_chan = {nib_in[2:0], 1'b0};
            n.conv_neg  = {nib_in[2:0], 1'b1};
          end else begin
            n.conv_chan = nib_in;
            n.conv_neg  = nib_in;
          end
          n.state = adc_seq_pkg::ST_WAIT;
        end
      end
      adc_seq_pkg::ST_WAIT: begin
        if (conv_done) begin
          if (r.loopback) n.lb_code = r.lb_code + 10'h001;
          if (r.avg_cnt + 7'h01 == avg_goal) begin
            fifo_wr[r.cur] = !fifo_full[r.cur];
            ovf_set[r.cur] = fifo_full[r.cur];
            n.avg_cnt = '0;
            n.acc     = '0;
            if (last_step) begin
              pend_clr[r.cur] = 1'b1;
              n.state = adc_seq_pkg::ST_IDLE;
            end else begin
              n.step  = r.step + 3'h1;
              n.state = adc_seq_pkg::ST_ISSUE;
            end
          end else begin
            n.avg_cnt = r.avg_cnt + 7'h01;
            n.acc     = acc_sum;
            n.state   = adc_seq_pkg::ST_ISSUE;
          end
        end
      end
      default: n.state = adc_seq_pkg::ST_IDLE;
    endcase

    // Sticky flags: a new event in the clearing cycle survives.
    n.pending = ((r.pending & ~pend_clr) | hit) & r.enable;
    n.ovf     = (r.ovf & ~ovf_clr) | ovf_set;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      r        <= '0;
      r.pri    <= adc_seq_pkg::RST_PRIORITY;
      r.ctl[3] <= adc_seq_pkg::RST_CTL_LAST;
      r.state  <= adc_seq_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // Outputs.
  assign PRDATA        = r.prdata;
  assign PREADY        = PSEL && PENABLE && r.apb_wait;
  assign PSLVERR       = done_ph && !mapped;
  assign CONV_START    = r.conv_start;
  assign CONV_CHAN     = r.conv_chan;
  assign CONV_CHAN_NEG = r.conv_neg;
  assign CONV_DIFF     = r.conv_diff;
  assign CONV_TEMP     = r.conv_temp;

endmodule // adc_sequencer

`default_nettype wire

// File: rtl/adc_seq_pkg.sv
// Shared constants and types of the converter sequencer block.
// Assumes a 32-bit APB slave port and a 10-bit converter core beside it.

package adc_seq_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NSEQ   = 4;
  localparam int NTRIG  = 4;
  localparam int CODE_W = 10;
  localparam int ACC_W  = 16;

  // Steps and result depth of each sequencer.
  localparam int SEQ_DEPTH [NSEQ] = '{8, 4, 4, 1};
  localparam logic [31:0] SEQ_MASK [NSEQ] =
    '{32'hffffffff, 32'h0000ffff, 32'h0000ffff, 32'h0000000f};

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_ACTIVE   = 12'h000;
  localparam logic [11:0] OFF_OVERFLOW = 12'h010;
  localparam logic [11:0] OFF_EVENT    = 12'h014;
  localparam logic [11:0] OFF_PRIORITY = 12'h020;
  localparam logic [11:0] OFF_INITIATE = 12'h028;
  localparam logic [11:0] OFF_AVERAGE  = 12'h030;
  localparam logic [11:0] OFF_LOOPBACK = 12'h100;
  // Sequencer n block starts at 0x040 + 0x020 * n.
  localparam logic [2:0]  SEQ_BLK_FIRST = 3'h2;
  localparam logic [2:0]  SEQ_BLK_LAST  = 3'h5;
  localparam logic [4:0]  SUB_MUX  = 5'h00;
  localparam logic [4:0]  SUB_CTL  = 5'h04;
  localparam logic [4:0]  SUB_FIFO = 5'h08;
  localparam logic [4:0]  SUB_STAT = 5'h0c;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTL_DIFF   = 0;
  localparam int CTL_END    = 1;
  localparam int CTL_IE     = 2;
  localparam int CTL_TEMP   = 3;
  localparam int STAT_EMPTY = 8;
  localparam int STAT_FULL  = 12;
  localparam logic [15:0] PRI_MASK     = 16'h3333;
  localparam logic [15:0] RST_PRIORITY = 16'h3210;
  localparam logic [31:0] RST_CTL_LAST = 32'h00000002;
  localparam logic [2:0]  SAC_MAX      = 3'h6;
  localparam logic [10:0] DIFF_ZERO    = 11'h1ff;

  // ---------------------------------------------------------------
  // Trigger event codes
  // ---------------------------------------------------------------
  localparam logic [3:0] TRIG_PROC      = 4'h0;
  localparam logic [3:0] TRIG_EXT_FIRST = 4'h1;
  localparam logic [3:0] TRIG_EXT_LAST  = 4'h4;
  localparam logic [3:0] TRIG_ALWAYS    = 4'hf;

  // ---------------------------------------------------------------
  // Sequence engine states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b11
  } seq_state_e;

endpackage

// File: rtl/result_fifo.sv
// Result buffer of one sequencer: a small circular buffer of codes.
// Ignores a write while full and a read while empty, so callers need not check.
`timescale 1ns/100ps
`default_nettype none

module result_fifo #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 10
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  full,
  output logic                  empty
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic [WIDTH-1:0]            rdata;
  } fifo_s;

  fifo_s r;
  fifo_s n;

  // Head word is registered, so it trails a pointer move by a cycle.
  always_comb begin
    n = r;
    n.rdata = r.mem[r.rptr];
    if (wr_en && !full) begin
      n.mem[r.wptr] = wr_data;
      n.wptr = (r.wptr == LAST) ? '0 : r.wptr + AW'(1);
    end
    if (rd_en && !empty) begin
      n.rptr = (r.rptr == LAST) ? '0 : r.rptr + AW'(1);
    end
    n.count = r.count + (AW + 1)'(wr_en && !full)
                      - (AW + 1)'(rd_en && !empty);
  end

  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rd_data = r.rdata;
  assign full    = (r.count == FULL_CNT);
  assign empty   = (r.count == '0);

endmodule // result_fifo

`default_nettype wire

// File: tb/conv_core_model.sv
// Behavioural converter core: one done pulse per start, after lat cycles.
// Assumes registered start pulses on the sequencer's own clock.
`timescale 1ns/100ps
`default_nettype none

module conv_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       conv_start,
  input  wire logic [3:0] chan,
  input  wire logic [3:0] chan_neg,
  input  wire logic       diff,
  input  wire logic [3:0] lat,
  output logic            conv_done,
  output logic      [9:0] conv_code
);
  // Levels of the four inputs, as single-ended codes.
  localparam logic [9:0] VIN [4] = '{10'h000, 10'h120, 10'h3ff, 10'h2f0};
  logic [3:0] cnt;
  logic [9:0] res;

  // The code bus toggles outside the done pulse, so a stale value is
  // never mistaken for a fresh result.
  always_ff @(posedge clk) begin
    conv_done <= 1'b0;
    conv_code <= ~conv_code;
    if (rst) begin
      cnt <= 4'h0;
      conv_code <= 10'h000;
    end else if (conv_start) begin
      cnt <= lat;
      res <= diff ? VIN[chan[1:0]] - VIN[chan_neg[1:0]] : VIN[chan[1:0]];
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        conv_done <= 1'b1;
        conv_code <= res;
      end
    end
  end
endmodule // conv_core_model
`default_nettype wire

// File: tb/adc_sequencer_properties.sv
// Port-level assertions for the converter sequencer.
// Assumes a master that holds each APB request until PREADY.
`timescale 1ns/100ps
`default_nettype none

module adc_sequencer_properties (
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        CONV_START,
  input wire logic [3:0]  CONV_CHAN,
  input wire logic [3:0]  CONV_CHAN_NEG,
  input wire logic        CONV_DIFF,
  input wire logic        CONV_DONE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  ready_needs_access_a: assert property (
    PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  one_wait_state_a: assert property (
    PSEL && !PENABLE ##1 PSEL && PENABLE |-> !PREADY ##1 PREADY)
    else $error("wait state count wrong");
  error_with_ready_a: assert property (
    PSLVERR |-> PREADY) else $error("error without ready");
  unmapped_reads_zero_a: assert property (
    PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  start_one_cycle_a: assert property (
    CONV_START |=> !CONV_START) else $error("start pulse too long");
  diff_pair_a: assert property (
    CONV_START && CONV_DIFF |-> !CONV_CHAN[0] &&
    CONV_CHAN_NEG == CONV_CHAN + 4'h1) else $error("bad pair");
  single_chan_a: assert property (
    CONV_START && !CONV_DIFF |-> CONV_CHAN_NEG == CONV_CHAN)
    else $error("single input mismatch");
  done_gap_a: assert property (
    CONV_DONE |=> !CONV_START) else $error("start right after done");
  reset_quiet_a: assert property (disable iff (1'b0)
    SRST |=> !CONV_START) else $error("start during reset");

  cover property (CONV_START && CONV_DIFF);
  cover property (PREADY && PSLVERR);
  cover property (CONV_DONE ##2 CONV_START);
endmodule // adc_sequencer_properties

bind adc_sequencer adc_sequencer_properties chk (.CLOCK, .SRST, .PSEL,
  .PENABLE, .PWRITE, .PRDATA, .PREADY, .PSLVERR, .CONV_START, .CONV_CHAN,
  .CONV_CHAN_NEG, .CONV_DIFF, .CONV_DONE);
`default_nettype wire

// File: tb/test_adc_sequencer.sv
// Self-checking bench for the converter sequencer over APB.
// Assumes the core model on the converter side.
`timescale 1ns/100ps
`default_nettype none

module test_adc_sequencer;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic        CLOCK = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic        PWRITE = 1'b0, PREADY, PSLVERR, er;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [3:0]  TRIG_IN = 4'h0, CONV_CHAN, CONV_CHAN_NEG, lat = 4'h1;
  logic        CONV_START, CONV_DIFF, CONV_TEMP, CONV_DONE;
  logic [9:0]  CONV_CODE;
  int          fails = 0, total_checks = 0, starts = 0, cycles = 0, s0;

  adc_sequencer dut (.CLOCK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .TRIG_IN, .CONV_START, .CONV_CHAN,
    .CONV_CHAN_NEG, .CONV_DIFF, .CONV_TEMP, .CONV_DONE, .CONV_CODE);
  conv_core_model core (.clk(CLOCK), .rst(SRST), .conv_start(CONV_START),
    .chan(CONV_CHAN), .chan_neg(CONV_CHAN_NEG), .diff(CONV_DIFF),
    .lat, .conv_done(CONV_DONE), .conv_code(CONV_CODE));

  // Clock; counts starts, and a hung run is cut short here.
  always #25 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles++;
    if (CONV_START === 1'b1) starts++;
    if (cycles == 40000) begin
      fails++;
      wrap_up;
    end
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  // Ready is sampled at the rising edge, as the slave sees it; the
  // request stands until that edge and is released right after it.
  // Only the bench timeout ends a wait that never sees ready.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask

  // Waits until sequencer n's buffer is not empty, then pops one entry.
  task pop(input logic [11:0] b, input logic [9:0] e);
    do begin
      apb(1'b0, b + 12'h00c, 32'h0);
    end while (rd[8] !== 1'b0);
    rdchk(b + 12'h008, {22'h0, e}, "entry");
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_reset;
    rdchk(12'h020, 32'h00003210, "priority");
    rdchk(12'h0a4, 32'h00000002, "ctl3");
    rdchk(12'h030, 32'h0, "average");
    rdchk(12'h04c, 32'h00000100, "stat0");
    apb(1'b0, 12'h0fc, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
  endtask

  // Input 2 sits at full scale in the core model, input 0 at zero.
  task t_single;
    apb(1'b1, 12'h0a0, 32'h2);
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h028, 32'h8);
    pop(12'h0a0, 10'h3ff);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h0a0, 32'h0);
    rdchk(12'h0a0, 32'h0, "mux3");
    apb(1'b1, 12'h0a4, 32'ha);
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h028, 32'h8);
    pop(12'h0a0, 10'h000);
    chk("temp", 32'h1, {31'h0, CONV_TEMP});
  endtask

  task t_diff;
    lat <= 4'h9;
    apb(1'b1, 12'h060, 32'h10);
    apb(1'b1, 12'h064, 32'h31);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h028, 32'h2);
    pop(12'h060, 10'h1ff + 10'h000 - 10'h120);
    pop(12'h060, 10'h1ff + 10'h3ff - 10'h2f0);
    lat <= 4'h1;
  endtask

  task t_avg;
    apb(1'b1, 12'h030, 32'h6);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h0a0, 32'h1);
    apb(1'b1, 12'h000, 32'h8);
    s0 = starts;
    apb(1'b1, 12'h028, 32'h8);
    pop(12'h0a0, 10'h120);
    chk("avg64", 32'd64, starts - s0);
    apb(1'b1, 12'h030, 32'h1);
    apb(1'b1, 12'h000, 32'h2);
    s0 = starts;
    apb(1'b1, 12'h028, 32'h2);
    pop(12'h060, 10'h1ff - 10'h120);
    pop(12'h060, 10'h1ff + 10'h10f);
    chk("avg2", 32'd4, starts - s0);
    apb(1'b1, 12'h030, 32'h0);
  endtask

  task t_trig;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h014, 32'h1000);
    apb(1'b1, 12'h000, 32'h8);
    s0 = starts;
    TRIG_IN <= 4'h1;
    pop(12'h0a0, 10'h120);
    chk("ext", 32'd1, starts - s0);
    TRIG_IN <= 4'h0;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h014, 32'hf000);
    apb(1'b1, 12'h000, 32'h8);
    s0 = starts;
    repeat (60) @(posedge CLOCK);
    apb(1'b1, 12'h000, 32'h0);
    repeat (20) @(posedge CLOCK);
    chk("always", 32'h1, {31'h0, starts - s0 > 1});
    pop(12'h0a0, 10'h120);
    // The one-entry buffer of sequencer 3 must have dropped the rest.
    rdchk(12'h010, 32'h8, "overflow");
    apb(1'b1, 12'h010, 32'h8);
    rdchk(12'h010, 32'h0, "overflow clear");
  endtask

  task t_loop;
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h100, 32'h1);
    apb(1'b1, 12'h000, 32'h8);
    s0 = starts;
    apb(1'b1, 12'h028, 32'h8);
    pop(12'h0a0, 10'h000);
    apb(1'b1, 12'h028, 32'h8);
    pop(12'h0a0, 10'h001);
    chk("nostart", 32'd0, starts - s0);
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (12) @(posedge CLOCK);
    SRST <= 1'b0;
    t_reset;
    t_single;
    t_diff;
    t_avg;
    t_trig;
    t_loop;
    wrap_up;
  end
endmodule // test_adc_sequencer
`default_nettype wire
